// >>> core/cmtv_pkg.sv
package cmtv_pkg;
   // ----------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------------
   localparam logic [15:0] CMTV_IDX_COUNT_CONTROL   = 16'hFFB8; // Clock, clear, irq enables
   localparam logic [15:0] CMTV_IDX_FLAGS_OUT_SEL   = 16'hFFB9; // Flags and output select
   localparam logic [15:0] CMTV_IDX_COMPARE_A       = 16'hFFBA; // Compare value A
   localparam logic [15:0] CMTV_IDX_COMPARE_B       = 16'hFFBB; // Compare value B
   localparam logic [15:0] CMTV_IDX_UP_COUNTER      = 16'hFFBC; // Counter value
   localparam logic [15:0] CMTV_IDX_TRIGGER_CONTROL = 16'hFFBD; // Trigger and extra clock

   // ----------------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------------
   localparam logic [7:0] CMTV_RST_COUNT_CONTROL   = 8'h00;
   localparam logic [7:0] CMTV_RST_FLAGS_OUT_SEL   = 8'h10;
   localparam logic [7:0] CMTV_RST_COMPARE         = 8'hFF;
   localparam logic [7:0] CMTV_RST_UP_COUNTER      = 8'h00;
   localparam logic [7:0] CMTV_RST_TRIGGER_CONTROL = 8'hE2;
   localparam logic [7:0] CMTV_COUNT_MAX           = 8'hFF;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int CMTV_B_MATCH_B_IRQ_EN = 7; // count_control
   localparam int CMTV_B_MATCH_A_IRQ_EN = 6;
   localparam int CMTV_B_WRAP_IRQ_EN    = 5;
   localparam int CMTV_B_CLEAR_SEL_HI   = 4;
   localparam int CMTV_B_CLEAR_SEL_LO   = 3;
   localparam int CMTV_B_CLOCK_SEL_HI   = 2;
   localparam int CMTV_B_MATCH_B_FLAG   = 7; // flags_and_output_select
   localparam int CMTV_B_MATCH_A_FLAG   = 6;
   localparam int CMTV_B_WRAP_FLAG      = 5;
   localparam int CMTV_B_OUT_SEL_B_HI   = 3;
   localparam int CMTV_B_OUT_SEL_A_HI   = 1;
   localparam int CMTV_B_TRIG_EDGE_HI   = 4; // trigger_control
   localparam int CMTV_B_TRIGGER_ENABLE = 2;
   localparam int CMTV_B_EXTRA_CLK_SEL  = 0;
   localparam logic [7:0] CMTV_FLAGS_FIXED_ONES = 8'h10; // Reserved bit reads 1
   localparam logic [7:0] CMTV_TRIG_FIXED_ONES  = 8'hE2; // Reserved bits read 1
   localparam logic [7:0] CMTV_TRIG_WR_MASK     = 8'h1D; // Writable trigger bits

   // ----------------------------------------------------------------------
   // Encodings and widths
   // ----------------------------------------------------------------------
   localparam logic [1:0] CMTV_CLR_NONE    = 2'h0;
   localparam logic [1:0] CMTV_CLR_MATCH_A = 2'h1;
   localparam logic [1:0] CMTV_CLR_MATCH_B = 2'h2;
   localparam logic [1:0] CMTV_CLR_EXT_PIN = 2'h3;
   localparam logic [1:0] CMTV_OUT_KEEP    = 2'h0;
   localparam logic [1:0] CMTV_OUT_LOW     = 2'h1;
   localparam logic [1:0] CMTV_OUT_HIGH    = 2'h2;
   localparam logic [1:0] CMTV_OUT_TOGGLE  = 2'h3;
   localparam int         CMTV_PRESCALE_W  = 7;   // Divides down to one 128th
   localparam int         CMTV_ADDR_W_MIN  = 18;
endpackage

// >>> core/cmtv_top.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// [RL1] Eight-bit up-counter on selected clock
// [RL2] Six internal prescaled clocks plus external pin
// [RL3] Counter readable and writable at any time
// [RL4] Clear by pin, match A or B
// [RL5] Wrap from maximum to zero sets flag
// [RL6] Counter zero on reset and low power
// [RL7] Compare A always, except during its write
// [RL8] Match A sets flag, enabled requests interrupt
// [RL9] Compare B behaves like compare A
// [RL10] Output pin driven by matches per select
// [RL11] Compare A all ones on reset, low power
// [RL12] Trigger pin edge starts counting, edge selectable
// [RL13] Count stop halts counter when cleared
// [RL14] Three interrupt requests: two matches, one wrap
// [RL15] Top three status bits: write zero clears only
// [RL16] Reset values of all six registers
// [RL17] External clock pin and external reset pin
// [RL18] Two independent matches shape output waveform
// [RL19] Clear field decode: none, A, B, pin rise
// [RL20] Clock select decode with extra select bit
// [RL21] Flag clears after read as one, write zero
// [RL22] Trigger enable halts on clear, resumes on edge
// [RL23] CPU counter write beats count increment
module cmtv_top #(
   parameter int ADDR_W = cmtv_pkg::CMTV_ADDR_W_MIN // Byte address width
) (
   input  wire  logic              clock_i,            // System clock, 40 MHz
   input  wire  logic              rst_i,              // Synchronous reset, active high
   input  wire  logic              low_power_i,        // Standby, watch, subsleep, subactive
   input  wire  logic [ADDR_W-1:0] avs_address_i,      // Byte address
   input  wire  logic              avs_read_i,         // Read request
   input  wire  logic              avs_write_i,        // Write request
   input  wire  logic [31:0]       avs_writedata_i,    // Write data, low byte used
   input  wire  logic [3:0]        avs_byteenable_i,   // Byte lanes
   output logic [31:0]             avs_readdata_o,     // Read data
   output logic                    avs_waitrequest_o,  // Stall the master
   input  wire  logic              ext_clock_pin_i,    // External count clock
   input  wire  logic              ext_reset_pin_i,    // External counter clear
   input  wire  logic              trigger_pin_i,      // Counting trigger
   output logic                    waveform_out_pin_o, // Compare match waveform
   output logic                    match_a_irq_o,      // Interrupt request, match A
   output logic                    match_b_irq_o,      // Interrupt request, match B
   output logic                    wrap_irq_o          // Interrupt request, wrap
);
   import cmtv_pkg::*;

   // ----------------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------------
   if (ADDR_W < CMTV_ADDR_W_MIN) begin : g_addr_check
      $error("cmtv_top: ADDR_W too small for register map");
   end

   // ----------------------------------------------------------------------
   // Registers and state
   // ----------------------------------------------------------------------
   logic [7:0]                 count_control_reg;     // Enables, clear and clock select
   logic [7:0]                 flags_reg;             // Flags [7:5], output select [3:0]
   logic [7:0]                 compare_value_a_reg;   // Compare A
   logic [7:0]                 compare_value_b_reg;   // Compare B
   logic [7:0]                 up_counter_reg;        // The counter
   logic [7:0]                 trigger_control_reg;   // Trigger edge, enable, extra select
   logic [2:0]                 armed_reg;             // Flags seen as one by a read
   logic                       wait_reg;              // Waitrequest, high while idle
   logic [31:0]                readdata_reg;          // Read answer
   logic [CMTV_PRESCALE_W-1:0] prescale_reg;          // Free-running divider
   logic                       ext_clk_prev_reg;      // Pin history for edge detection
   logic                       ext_rst_prev_reg;
   logic                       trig_prev_reg;
   logic                       eq_a_prev_reg;         // Equality one cycle ago
   logic                       eq_b_prev_reg;
   logic                       run_reg;               // Counting released by trigger
   logic                       wave_reg;              // Waveform pin level
   logic [2:0]                 irq_reg;               // B, A, wrap requests

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------
   logic [15:0] idx;       // Register index from byte address
   logic        wr_acc;    // Write takes effect this edge
   logic        rd_acc;    // Read data captured this edge
   logic        lane0;     // Low byte lane enabled
   logic [7:0]  wdata;     // Written byte
   assign idx    = avs_address_i[17:2];
   assign wr_acc = avs_write_i && !wait_reg;
   assign rd_acc = avs_read_i && wait_reg;
   assign lane0  = avs_byteenable_i[0];
   assign wdata  = avs_writedata_i[7:0];
   logic wr_ctl;   // Per-register write strobes
   logic wr_flg;
   logic wr_cpa;
   logic wr_cpb;
   logic wr_cnt;
   logic wr_trg;
   assign wr_ctl = wr_acc && lane0 && (idx == CMTV_IDX_COUNT_CONTROL);
   assign wr_flg = wr_acc && lane0 && (idx == CMTV_IDX_FLAGS_OUT_SEL);
   assign wr_cpa = wr_acc && lane0 && (idx == CMTV_IDX_COMPARE_A);
   assign wr_cpb = wr_acc && lane0 && (idx == CMTV_IDX_COMPARE_B);
   assign wr_cnt = wr_acc && lane0 && (idx == CMTV_IDX_UP_COUNTER);
   assign wr_trg = wr_acc && lane0 && (idx == CMTV_IDX_TRIGGER_CONTROL);

   // Handshake: one wait cycle, then a single accepted edge
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         wait_reg <= 1'b1;
      end else if ((avs_read_i || avs_write_i) && wait_reg) begin
         wait_reg <= 1'b0;
      end else begin
         wait_reg <= 1'b1;
      end
   end

   // Read mux, captured one cycle ahead so data stand at the accepting edge
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         readdata_reg <= 32'h0000_0000;
      end else if (rd_acc) begin
         readdata_reg <= 32'h0000_0000;   // Unmapped reads return zero
         unique case (idx)
            CMTV_IDX_COUNT_CONTROL:   readdata_reg[7:0] <= count_control_reg;
            CMTV_IDX_FLAGS_OUT_SEL:   readdata_reg[7:0] <= flags_reg | CMTV_FLAGS_FIXED_ONES;
            CMTV_IDX_COMPARE_A:       readdata_reg[7:0] <= compare_value_a_reg;
            CMTV_IDX_COMPARE_B:       readdata_reg[7:0] <= compare_value_b_reg;
            CMTV_IDX_UP_COUNTER:      readdata_reg[7:0] <= up_counter_reg;   // [RL3]
            CMTV_IDX_TRIGGER_CONTROL: readdata_reg[7:0] <= trigger_control_reg;
            default:                  readdata_reg[7:0] <= 8'h00;
         endcase
      end
   end

   assign avs_readdata_o    = readdata_reg;
   assign avs_waitrequest_o = wait_reg;

   // ----------------------------------------------------------------------
   // Count clock selection
   // ----------------------------------------------------------------------
   logic [2:0] clk_sel;     // Three clock select bits
   logic       extra_sel;   // Extra clock select bit
   logic       ext_rise;    // External clock edges
   logic       ext_fall;
   logic       tick;        // One count this cycle
   assign clk_sel   = count_control_reg[CMTV_B_CLOCK_SEL_HI -: 3];
   assign extra_sel = trigger_control_reg[CMTV_B_EXTRA_CLK_SEL];
   assign ext_rise  = ext_clock_pin_i && !ext_clk_prev_reg;
   assign ext_fall  = !ext_clock_pin_i && ext_clk_prev_reg;
   // Divider runs from reset so every tap is phase aligned
   always_ff @(posedge clock_i) begin
      if (rst_i || low_power_i) begin
         prescale_reg <= '0;
      end else begin
         prescale_reg <= prescale_reg + 1'b1;   // [RL2]
      end
   end

   // Internal tap of 2^k cycles: tick where its low k bits roll over
   always_comb begin
      tick = 1'b0;
      unique case (clk_sel)
         3'h1: tick = extra_sel ? (&prescale_reg[2:0]) : (&prescale_reg[1:0]); // [RL20]
         3'h2: tick = extra_sel ? (&prescale_reg[4:0]) : (&prescale_reg[3:0]); // [RL20]
         3'h3: tick = extra_sel ? (&prescale_reg[6:0]) : (&prescale_reg[5:0]); // [RL2]
         3'h5: tick = ext_rise;                                                // [RL17]
         3'h6: tick = ext_fall;                                                // [RL17]
         3'h7: tick = ext_rise || ext_fall;                                    // [RL20]
         default: tick = 1'b0;   // Codes 000 and 100 stop the count
      endcase
   end

   // ----------------------------------------------------------------------
   // Compare, clear and trigger events
   // ----------------------------------------------------------------------
   logic       eq_a;       // Compare A equals counter
   logic       eq_b;
   logic       match_a;    // One pulse per match
   logic       match_b;
   logic [1:0] clr_sel;
   logic       clear_ev;   // Counter clear requested
   logic [1:0] trig_sel;
   logic       trig_ev;    // Selected trigger edge
   logic       trig_en;
   logic       counting;
   logic       wrap_ev;

   // Compare A is blind while software rewrites it
   assign eq_a    = (up_counter_reg == compare_value_a_reg) && !wr_cpa;   // [RL7]
   assign eq_b    = (up_counter_reg == compare_value_b_reg) && !wr_cpb;   // [RL9]
   // A held equality must not retoggle the pin each cycle
   assign match_a = eq_a && !eq_a_prev_reg;
   assign match_b = eq_b && !eq_b_prev_reg;
   assign clr_sel = count_control_reg[CMTV_B_CLEAR_SEL_HI -: 2];

   always_comb begin
      clear_ev = 1'b0;
      unique case (clr_sel)
         CMTV_CLR_NONE:    clear_ev = 1'b0;                                 // [RL19]
         CMTV_CLR_MATCH_A: clear_ev = match_a;                              // [RL4]
         CMTV_CLR_MATCH_B: clear_ev = match_b;                              // [RL4]
         CMTV_CLR_EXT_PIN: clear_ev = ext_reset_pin_i && !ext_rst_prev_reg; // [RL17]
      endcase
   end

   assign trig_sel = trigger_control_reg[CMTV_B_TRIG_EDGE_HI -: 2];
   assign trig_en  = trigger_control_reg[CMTV_B_TRIGGER_ENABLE];
   assign trig_ev  = (trig_sel[0] && trigger_pin_i && !trig_prev_reg)
                  || (trig_sel[1] && !trigger_pin_i && trig_prev_reg);   // [RL12]
   assign counting = !trig_en || run_reg;
   assign wrap_ev  = tick && counting && !wr_cnt && !clear_ev
                  && (up_counter_reg == CMTV_COUNT_MAX);

   // Pin and equality history
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         ext_clk_prev_reg <= 1'b0;
         ext_rst_prev_reg <= 1'b0;
         trig_prev_reg    <= 1'b0;
         eq_a_prev_reg    <= 1'b0;
         eq_b_prev_reg    <= 1'b0;
      end else begin
         ext_clk_prev_reg <= ext_clock_pin_i;
         ext_rst_prev_reg <= ext_reset_pin_i;
         trig_prev_reg    <= trigger_pin_i;
         eq_a_prev_reg    <= eq_a;
         eq_b_prev_reg    <= eq_b;
      end
   end

   // Trigger gate: an edge releases, a clear halts; release wins a tie
   always_ff @(posedge clock_i) begin
      if (rst_i || low_power_i) begin
         run_reg <= 1'b0;
      end else if (trig_ev) begin
         run_reg <= 1'b1;            // [RL22]
      end else if (clear_ev && trig_en) begin
         run_reg <= 1'b0;            // [RL13]
      end
   end

   // ----------------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (rst_i || low_power_i) begin
         up_counter_reg <= CMTV_RST_UP_COUNTER;      // [RL6]
      end else if (wr_cnt) begin
         up_counter_reg <= wdata;                    // [RL23]
      end else if (clear_ev) begin
         up_counter_reg <= 8'h00;                    // [RL4]
      end else if (tick && counting) begin
         up_counter_reg <= up_counter_reg + 8'h01;   // [RL1]
      end
   end

   // ----------------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (rst_i || low_power_i) begin
         count_control_reg   <= CMTV_RST_COUNT_CONTROL;     // [RL16]
         compare_value_a_reg <= CMTV_RST_COMPARE;           // [RL11]
         compare_value_b_reg <= CMTV_RST_COMPARE;           // [RL9]
         trigger_control_reg <= CMTV_RST_TRIGGER_CONTROL;   // [RL16]
      end else begin
         if (wr_ctl) begin
            count_control_reg <= wdata;
         end
         if (wr_cpa) begin
            compare_value_a_reg <= wdata;
         end
         if (wr_cpb) begin
            compare_value_b_reg <= wdata;
         end
         if (wr_trg) begin
            trigger_control_reg <= (wdata & CMTV_TRIG_WR_MASK) | CMTV_TRIG_FIXED_ONES;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Flags and output select
   // ----------------------------------------------------------------------
   logic [2:0] set_ev;   // Hardware sets: B, A, wrap
   assign set_ev = {match_b, match_a, wrap_ev};
   // Flags only clear after being read as one; a set in the same cycle wins
   always_ff @(posedge clock_i) begin
      if (rst_i || low_power_i) begin
         flags_reg <= CMTV_RST_FLAGS_OUT_SEL;                      // [RL16]
         armed_reg <= 3'h0;
      end else begin
         if (wr_flg) begin
            flags_reg[3:0] <= wdata[3:0];
            armed_reg      <= 3'h0;
         end else if (rd_acc && (idx == CMTV_IDX_FLAGS_OUT_SEL)) begin
            armed_reg <= armed_reg | flags_reg[CMTV_B_MATCH_B_FLAG -: 3];   // [RL21]
         end
         for (int i = 0; i < 3; i++) begin
            if (set_ev[i]) begin
               flags_reg[CMTV_B_WRAP_FLAG + i] <= 1'b1;            // [RL5]
            end else if (wr_flg && !wdata[CMTV_B_WRAP_FLAG + i] && armed_reg[i]) begin
               flags_reg[CMTV_B_WRAP_FLAG + i] <= 1'b0;            // [RL15]
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Waveform output; B takes priority when both matches coincide
   // ----------------------------------------------------------------------
   logic [1:0] os_a;
   logic [1:0] os_b;
   logic [1:0] os_act;   // Action chosen this cycle
   logic       wave_next;
   assign os_a   = flags_reg[CMTV_B_OUT_SEL_A_HI -: 2];
   assign os_b   = flags_reg[CMTV_B_OUT_SEL_B_HI -: 2];
   assign os_act = match_b ? os_b : (match_a ? os_a : CMTV_OUT_KEEP);   // [RL18]
   always_comb begin
      wave_next = wave_reg;
      unique case (os_act)
         CMTV_OUT_KEEP:   wave_next = wave_reg;
         CMTV_OUT_LOW:    wave_next = 1'b0;        // [RL10]
         CMTV_OUT_HIGH:   wave_next = 1'b1;        // [RL10]
         CMTV_OUT_TOGGLE: wave_next = !wave_reg;   // [RL10]
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (rst_i || low_power_i) begin
         wave_reg <= 1'b0;
      end else begin
         wave_reg <= wave_next;
      end
   end

   assign waveform_out_pin_o = wave_reg;

   // ----------------------------------------------------------------------
   // Interrupt requests, a level while flag and enable are both one
   // ----------------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (rst_i || low_power_i) begin
         irq_reg <= 3'h0;
      end else begin
         irq_reg <= flags_reg[CMTV_B_MATCH_B_FLAG -: 3]
                  & count_control_reg[CMTV_B_MATCH_B_IRQ_EN -: 3];   // [RL14]
      end
   end
   assign match_b_irq_o = irq_reg[2];   // [RL9]
   assign match_a_irq_o = irq_reg[1];   // [RL8]
   assign wrap_irq_o    = irq_reg[0];

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   sequence s_cnt_write;
      wr_cnt;
   endsequence
   sequence s_match_a_seen;
      match_a && !low_power_i;
   endsequence
   property p_wrap;
      @(posedge clock_i) disable iff (rst_i)
      wrap_ev && !low_power_i |=> flags_reg[CMTV_B_WRAP_FLAG] && up_counter_reg == 8'h00;
   endproperty
   property p_flag_a_irq;
      @(posedge clock_i) disable iff (rst_i)
      s_match_a_seen ##1 (count_control_reg[CMTV_B_MATCH_A_IRQ_EN] && !low_power_i)
      |=> match_a_irq_o;
   endproperty
   AST_CNT_WRITE_WINS: assert property (@(posedge clock_i) disable iff (rst_i) // [RL23]
      s_cnt_write ##0 !low_power_i |=> up_counter_reg == $past(wdata))
      else $error("counter write lost");
   AST_LOW_POWER_INIT: assert property (@(posedge clock_i) disable iff (rst_i) // [RL6]
      low_power_i |=> up_counter_reg == 8'h00 && compare_value_a_reg == 8'hFF)
      else $error("low power did not initialise");
   AST_WRAP_FLAG: assert property (p_wrap) // [RL5]
      else $error("wrap flag not set");
   AST_MATCH_A_FLAG: assert property (@(posedge clock_i) disable iff (rst_i) // [RL8]
      s_match_a_seen |=> flags_reg[CMTV_B_MATCH_A_FLAG])
      else $error("match A flag not set");
   AST_MATCH_A_IRQ: assert property (p_flag_a_irq) // [RL8]
      else $error("match A interrupt missing");
   AST_NO_COMPARE_ON_WRITE: assert property (@(posedge clock_i) disable iff (rst_i) // [RL7]
      wr_cpa && !low_power_i && !flags_reg[CMTV_B_MATCH_A_FLAG] |=> !flags_reg[CMTV_B_MATCH_A_FLAG])
      else $error("compare A active during its write");
   AST_HALT_ON_CLEAR: assert property (@(posedge clock_i) disable iff (rst_i) // [RL13]
      clear_ev && trig_en && !trig_ev && !wr_cnt && !low_power_i
      ##1 (trig_en && !trig_ev && !wr_cnt && !low_power_i)[*2] |-> up_counter_reg == 8'h00)
      else $error("counter ran after stop on clear");
   AST_NO_SW_SET: assert property (@(posedge clock_i) disable iff (rst_i) // [RL15]
      !flags_reg[CMTV_B_WRAP_FLAG] && !wrap_ev ##1 1'b1 |-> !flags_reg[CMTV_B_WRAP_FLAG])
      else $error("wrap flag set without event");
   AST_BUS_ONE_WAIT: assert property (@(posedge clock_i) disable iff (rst_i) // [RL3]
      (avs_read_i || avs_write_i) && wait_reg |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("bus answer timing wrong");
endmodule

`default_nettype wire

// >>> bench/tb_compare_match_timer_v.sv
`timescale 1ns/1ps
`default_nettype none
module tb_compare_match_timer_v;
   import cmtv_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        clock_i, rst_i, low_power_i, avs_read_i, avs_write_i;
   logic [17:0] avs_address_i;                   // Byte address
   logic [31:0] avs_writedata_i, avs_readdata_o;
   logic        avs_waitrequest_o, waveform_out_pin_o;
   logic        match_a_irq_o, match_b_irq_o, wrap_irq_o;
   logic        ext_clock_pin_i, trigger_pin_i, ext_reset_pin_i;
   logic [7:0]  exp_q[$];                        // Expected read bytes, oldest first
   logic [7:0]  rv[6] = '{8'h00, 8'h10, 8'hFF, 8'hFF, 8'h00, 8'hE2};
   logic [7:0]  r;                               // Random counter value
   int          errors, tests_run;

   cmtv_top uut (.clock_i(clock_i), .rst_i(rst_i), .low_power_i(low_power_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .ext_clock_pin_i(ext_clock_pin_i), .ext_reset_pin_i(ext_reset_pin_i),
      .trigger_pin_i(trigger_pin_i), .waveform_out_pin_o(waveform_out_pin_o),
      .match_a_irq_o(match_a_irq_o), .match_b_irq_o(match_b_irq_o), .wrap_irq_o(wrap_irq_o));

   // ------------------------------------------------------------
   // Clock, checking and closing
   // ------------------------------------------------------------
   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Held request until waitrequest is sampled low, then released
   task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d);
      @(posedge clock_i);
      avs_address_i <= {idx, 2'b00};
      avs_writedata_i <= {24'h00_0000, d};
      avs_write_i <= w;
      avs_read_i <= !w;
      do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] idx, input logic [7:0] e);
      exp_q.push_back(e);
      bus(1'b0, idx, 8'h00);
   endtask
   // Slow pin edges so the synchronous edge detect cannot miss one
   task automatic pulse(input int which, input int n);
      repeat (n) begin
         @(posedge clock_i);
         if (which == 1) trigger_pin_i <= 1'b1;
         else if (which == 2) ext_reset_pin_i <= 1'b1;
         else ext_clock_pin_i <= 1'b1;
         repeat (3) @(posedge clock_i);
         {trigger_pin_i, ext_reset_pin_i, ext_clock_pin_i} <= 3'h0;
         repeat (3) @(posedge clock_i);
      end
   endtask
   // Read data is compared at the edge where the master takes it
   always @(posedge clock_i) begin
      if (avs_read_i && avs_waitrequest_o === 1'b0) begin
         chk(avs_readdata_o, {24'h00_0000, exp_q.pop_front()}, "read data");
      end
   end
   // Watchdog, far beyond the few hundred cycles the sequence needs
   initial begin
      #100_000;
      errors++;
      final_report();
   end

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(16));
      {rst_i, low_power_i, avs_read_i, avs_write_i} = 4'h8;
      {avs_address_i, avs_writedata_i, ext_clock_pin_i, trigger_pin_i, ext_reset_pin_i} = '0;
      repeat (4) @(posedge clock_i);
      rst_i <= 1'b0;
      foreach (rv[i]) rd(16'hFFB8 + 16'(i), rv[i]);
      rd(16'hFFBE, 8'h00);
      r = (8'($urandom) & 8'hF0) | 8'h08; // Never equal to a compare value
      bus(1'b1, CMTV_IDX_UP_COUNTER, r);
      rd(CMTV_IDX_UP_COUNTER, r);
      bus(1'b1, CMTV_IDX_FLAGS_OUT_SEL, 8'hFF);
      rd(CMTV_IDX_FLAGS_OUT_SEL, 8'h1F);
      bus(1'b1, CMTV_IDX_FLAGS_OUT_SEL, 8'h02);
      bus(1'b1, CMTV_IDX_COMPARE_A, 8'h05);
      bus(1'b1, CMTV_IDX_UP_COUNTER, 8'h00);
      bus(1'b1, CMTV_IDX_TRIGGER_CONTROL, 8'h0C);
      rd(CMTV_IDX_TRIGGER_CONTROL, 8'hEE);
      bus(1'b1, CMTV_IDX_COUNT_CONTROL, 8'h4D);
      pulse(1'b0, 2);
      rd(CMTV_IDX_UP_COUNTER, 8'h00);
      pulse(1'b1, 1);
      pulse(1'b0, 5);
      chk(match_a_irq_o, 1, "match a irq");
      chk(waveform_out_pin_o, 1, "waveform");
      rd(CMTV_IDX_FLAGS_OUT_SEL, 8'h52);
      pulse(1'b0, 2);
      rd(CMTV_IDX_UP_COUNTER, 8'h00);
      bus(1'b1, CMTV_IDX_FLAGS_OUT_SEL, 8'h02);
      rd(CMTV_IDX_FLAGS_OUT_SEL, 8'h12);
      chk(match_a_irq_o, 0, "match a irq");
      bus(1'b1, CMTV_IDX_TRIGGER_CONTROL, 8'h00);
      bus(1'b1, CMTV_IDX_COUNT_CONTROL, 8'hA5);
      bus(1'b1, CMTV_IDX_UP_COUNTER, 8'hFE);
      pulse(1'b0, 2);
      chk(wrap_irq_o, 1, "wrap irq");
      chk(match_b_irq_o, 1, "match b irq");
      rd(CMTV_IDX_FLAGS_OUT_SEL, 8'hB2);
      rd(CMTV_IDX_UP_COUNTER, 8'h00);
      low_power_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      low_power_i <= 1'b0;
      rd(CMTV_IDX_UP_COUNTER, 8'h00);
      rd(CMTV_IDX_COMPARE_A, 8'hFF);
      chk(wrap_irq_o, 0, "wrap irq");
      bus(1'b1, CMTV_IDX_COMPARE_B, 8'h03);
      bus(1'b1, CMTV_IDX_FLAGS_OUT_SEL, 8'h0C);
      bus(1'b1, CMTV_IDX_TRIGGER_CONTROL, 8'h14);
      bus(1'b1, CMTV_IDX_COUNT_CONTROL, 8'h15);
      pulse(1, 1);
      pulse(0, 3);
      chk(waveform_out_pin_o, 1, "waveform");
      rd(CMTV_IDX_FLAGS_OUT_SEL, 8'h9C);
      rd(CMTV_IDX_UP_COUNTER, 8'h00);
      bus(1'b1, CMTV_IDX_TRIGGER_CONTROL, 8'h00);
      bus(1'b1, CMTV_IDX_COUNT_CONTROL, 8'h1D);
      pulse(0, 2);
      rd(CMTV_IDX_UP_COUNTER, 8'h02);
      pulse(2, 1);
      rd(CMTV_IDX_UP_COUNTER, 8'h00);
      repeat (4) @(posedge clock_i);
      final_report();
   end
endmodule
`default_nettype wire
